// file: rtl/serial_ctrl.sv
// module: control, status and transmit logic of the asynchronous serial interface
// What this block does
// R1: nine-bit mode captures received ninth bit with the eight data bits; reset keeps it.
// R2: nine-bit mode sends stored ninth transmit bit with the data; reset keeps it.
// R3: character length bit selects nine bits when one, eight when zero; reset keeps it.
// R4: wakeup bit selects address-mark when one, idle-line when zero; reset keeps it.
// R5: transmit-empty enable raises interrupt while buffer-empty flag is set; reset clears enable.
// R6: transmit-done enable raises interrupt while done flag is set; reset clears enable.
// R7: receive enable raises interrupt on buffer full or overrun; reset clears enable.
// R8: line-quiet enable raises interrupt on idle flag; reset clears enable.
// R9: enabling transmitter first sends ten or eleven ones; reset clears enable.
// R10: receiver enable turns receiver and its interrupts on or off; flags untouched.
// R11: standby suspends reception; selected wakeup clears it; reset clears standby.
// R12: break bit sends repeated zero groups of ten or eleven bits; reset clears it.
// R13: clearing break finishes the group then drives a one on the line.
// R14: buffer-empty flag sets when transmit data moves into the shift register.
// R15: status read with flag set then data write clears buffer-empty.
// R16: reset sets buffer-empty and done; software clears both before enabling transmitter.
// R17: done flag sets when buffer empty and nothing shifts; cleared by read-then-write.
// R18: buffer-full sets on received data load; cleared by status then data read.
// R19: idle flag sets after a frame of ones; cleared by status then data read.
// R20: a character arriving while buffer full sets overrun and is discarded.
// R21: noise flag follows the buffered character; cleared by status then data read.
// R22: framing error flags zero stop bit, unless the character also overruns.
// R23: all enabled conditions form one level interrupt request.
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl #(
  parameter int SAMPLE_DIV = serial_pkg::SAMPLE_DIV
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // line
  input wire logic receive_pin_in,
  output logic transmit_pin_out,
  output logic transmit_drive_out,
  // interrupt request
  output logic irq_out
);
  rx_link_if link ();
  serial_rx_sampler u_rx (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .receive_pin_in(receive_pin_in),
    .link(link)
  );

  logic rx_ninth_bit_q, tx_ninth_bit_q, nine_bit_q, addr_mark_q;
  logic [7:0] enable_q;
  logic [7:0] rx_data_q, tx_data_q;
  logic tx_empty_q, tx_done_q, rx_full_q, idle_q, overrun_q, noise_q, frame_q;
  logic tx_arm_q, rx_arm_q;
  logic [15:0] div_q;
  logic [3:0] bit_sub_q;
  logic bit_tick;
  serial_pkg::tx_state_t tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_count_q;
  logic te_prev_q;
  logic wr, rd, wr_data, rd_data, rd_status;
  logic [7:0] status_word;
  logic [3:0] frame_len;
  logic addr_mark_hit, rx_take, tx_load, tx_busy_prev_q;

  assign link.nine_bits = nine_bit_q;
  assign link.enable = enable_q[serial_pkg::EN_RX];
  assign frame_len = nine_bit_q ? 4'(serial_pkg::FRAME_BITS_9) : 4'(serial_pkg::FRAME_BITS_8);

  // ---------------------------------------------
  // bus decode: one wait state, ack for every access
  // ---------------------------------------------
  assign wr = wb_cyc_in & wb_stb_in & ~wb_ack_out & wb_we_in & wb_sel_in[0];
  assign rd = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_we_in;
  assign wr_data = wr && wb_adr_in == serial_pkg::OFF_DATA;
  assign rd_data = rd && wb_adr_in == serial_pkg::OFF_DATA;
  assign rd_status = rd && wb_adr_in == serial_pkg::OFF_STATUS;
  assign status_word = {tx_empty_q, tx_done_q, rx_full_q, idle_q, overrun_q, noise_q, frame_q, 1'b0};

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      if (rd) begin
        if (wb_adr_in == serial_pkg::OFF_DATA) begin
          wb_dat_out <= {24'h000000, rx_data_q};
        end else if (wb_adr_in == serial_pkg::OFF_FORMAT) begin
          wb_dat_out <= {24'h000000, rx_ninth_bit_q, tx_ninth_bit_q, 1'b0, nine_bit_q, addr_mark_q, 3'h0};
        end else if (wb_adr_in == serial_pkg::OFF_ENABLE) begin
          wb_dat_out <= {24'h000000, enable_q};
        end else if (wb_adr_in == serial_pkg::OFF_STATUS) begin
          wb_dat_out <= {24'h000000, status_word};
        end else begin
          wb_dat_out <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------
  // format bits: kept across reset
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (wr && wb_adr_in == serial_pkg::OFF_FORMAT) begin
      tx_ninth_bit_q <= wb_dat_in[serial_pkg::FMT_TX_NINTH];
      nine_bit_q <= wb_dat_in[serial_pkg::FMT_NINE_BIT]; // R3
      addr_mark_q <= wb_dat_in[serial_pkg::FMT_ADDR_MARK]; // R4
    end
    if (rx_take && nine_bit_q) begin
      rx_ninth_bit_q <= link.char_data[8]; // R1
    end
  end

  // ---------------------------------------------
  // enable register and standby
  // ---------------------------------------------
  assign addr_mark_hit = nine_bit_q ? link.char_data[8] : link.char_data[7];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_q <= serial_pkg::ENABLE_RESET;
    end else begin
      if (wr && wb_adr_in == serial_pkg::OFF_ENABLE) begin
        enable_q <= wb_dat_in[7:0];
      end else if (enable_q[serial_pkg::EN_STANDBY] && enable_q[serial_pkg::EN_RX]) begin
        if (addr_mark_q ? (link.char_valid && addr_mark_hit) : link.line_idle) begin
          enable_q[serial_pkg::EN_STANDBY] <= 1'b0; // R11
        end
      end
    end
  end

  // ---------------------------------------------
  // receive data and flags
  // ---------------------------------------------
  assign rx_take = link.char_valid && enable_q[serial_pkg::EN_RX] && !rx_full_q
                   && (!enable_q[serial_pkg::EN_STANDBY] || (addr_mark_q && addr_mark_hit)); // R10 R11

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      idle_q <= 1'b0;
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      frame_q <= 1'b0;
      rx_arm_q <= 1'b0;
    end else begin
      if (rd_status) begin
        rx_arm_q <= 1'b1;
      end else if (rd_data) begin
        rx_arm_q <= 1'b0;
      end
      if (rd_data && rx_arm_q) begin
        rx_full_q <= 1'b0; // R18
        idle_q <= 1'b0; // R19
        overrun_q <= 1'b0; // R20
        noise_q <= 1'b0; // R21
        frame_q <= 1'b0; // R22
      end
      if (rx_take) begin
        rx_data_q <= link.char_data[7:0];
        rx_full_q <= 1'b1; // R18
        noise_q <= link.char_noise; // R21
        frame_q <= link.char_frame_err; // R22
      end else if (link.char_valid && enable_q[serial_pkg::EN_RX] && rx_full_q
                   && !enable_q[serial_pkg::EN_STANDBY]) begin
        overrun_q <= 1'b1; // R20
      end
      if (link.line_idle && enable_q[serial_pkg::EN_RX] && !enable_q[serial_pkg::EN_STANDBY]) begin
        idle_q <= 1'b1; // R19
      end
    end
  end

  // ---------------------------------------------
  // sample and bit rate enables
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q <= 16'h0000;
      link.sample_tick <= 1'b0;
      bit_sub_q <= 4'h0;
    end else begin
      link.sample_tick <= 1'b0;
      if (div_q == 16'(SAMPLE_DIV - 1)) begin
        div_q <= 16'h0000;
        link.sample_tick <= 1'b1;
        bit_sub_q <= bit_sub_q + 4'h1;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end
  assign bit_tick = link.sample_tick && bit_sub_q == 4'hf;

  // ---------------------------------------------
  // transmitter
  // ---------------------------------------------
  assign tx_load = tx_state_q == serial_pkg::TX_IDLE && bit_tick && enable_q[serial_pkg::EN_TX] && te_prev_q
                   && !enable_q[serial_pkg::EN_BREAK] && !tx_empty_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_q <= serial_pkg::TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_count_q <= 4'h0;
      te_prev_q <= 1'b0;
      transmit_pin_out <= 1'b1;
      transmit_drive_out <= 1'b0;
    end else begin
      if (bit_tick) begin
        te_prev_q <= enable_q[serial_pkg::EN_TX];
        transmit_pin_out <= tx_shift_q[0];
        transmit_drive_out <= enable_q[serial_pkg::EN_TX] || tx_state_q != serial_pkg::TX_IDLE;
        if (tx_count_q > 4'h1) begin
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_count_q <= tx_count_q - 4'h1;
        end else if (enable_q[serial_pkg::EN_TX] && !te_prev_q) begin
          tx_state_q <= serial_pkg::TX_PREAMBLE;
          tx_shift_q <= 11'h7ff; // R9
          tx_count_q <= frame_len; // R9
        end else if (enable_q[serial_pkg::EN_BREAK] && enable_q[serial_pkg::EN_TX]) begin
          tx_state_q <= serial_pkg::TX_BREAK;
          tx_shift_q <= 11'h000; // R12
          tx_count_q <= frame_len; // R12
        end else if (tx_state_q == serial_pkg::TX_BREAK) begin
          tx_state_q <= serial_pkg::TX_PREAMBLE;
          tx_shift_q <= 11'h7ff; // R13
          tx_count_q <= 4'h1; // R13
        end else if (enable_q[serial_pkg::EN_TX] && !tx_empty_q) begin
          tx_state_q <= serial_pkg::TX_DATA;
          tx_shift_q <= nine_bit_q ? {1'b1, tx_ninth_bit_q, tx_data_q, 1'b0}
                                   : {2'b11, tx_data_q, 1'b0}; // R2
          tx_count_q <= frame_len;
        end else begin
          tx_state_q <= serial_pkg::TX_IDLE;
          tx_shift_q <= 11'h7ff;
          tx_count_q <= 4'h0;
        end
      end
    end
  end

  // ---------------------------------------------
  // transmit buffer and flags
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_data_q <= 8'h00;
      tx_empty_q <= 1'b1; // R16
      tx_done_q <= 1'b1; // R16
      tx_arm_q <= 1'b0;
      tx_busy_prev_q <= 1'b0;
    end else begin
      if (bit_tick) begin
        tx_busy_prev_q <= tx_state_q != serial_pkg::TX_IDLE || tx_count_q != 4'h0;
      end
      if (rd_status) begin
        tx_arm_q <= 1'b1;
      end else if (wr_data) begin
        tx_arm_q <= 1'b0;
      end
      if (wr_data) begin
        tx_data_q <= wb_dat_in[7:0];
      end
      if (wr_data && tx_arm_q) begin
        tx_empty_q <= 1'b0; // R15
        tx_done_q <= 1'b0; // R17
      end
      if (bit_tick && tx_count_q <= 4'h1 && !(enable_q[serial_pkg::EN_TX] && !te_prev_q)
          && !enable_q[serial_pkg::EN_BREAK] && tx_state_q != serial_pkg::TX_BREAK
          && enable_q[serial_pkg::EN_TX] && !tx_empty_q) begin
        tx_empty_q <= 1'b1; // R14
      end
      if (bit_tick && tx_empty_q && tx_busy_prev_q && tx_state_q == serial_pkg::TX_IDLE && tx_count_q == 4'h0) begin
        tx_done_q <= 1'b1; // R17
      end
    end
  end

  // ---------------------------------------------
  // interrupt request
  // ---------------------------------------------
  logic irq_d;
  assign irq_d = (enable_q[serial_pkg::EN_TX_EMPTY_IRQ] & tx_empty_q) // R5
               | (enable_q[serial_pkg::EN_TX_DONE_IRQ] & tx_done_q) // R6
               | (enable_q[serial_pkg::EN_RX] & ~enable_q[serial_pkg::EN_STANDBY]
                  & ((enable_q[serial_pkg::EN_RX_FULL_IRQ] & (rx_full_q | overrun_q)) // R7
                     | (enable_q[serial_pkg::EN_LINE_QUIET_IRQ] & idle_q))); // R8 R10

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_d; // R23
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  tx_irq_a: assert property (enable_q[serial_pkg::EN_TX_EMPTY_IRQ] && tx_empty_q |=> irq_out) // R5
    else $error("empty interrupt missing");
  done_irq_a: assert property (enable_q[serial_pkg::EN_TX_DONE_IRQ] && tx_done_q |=> irq_out) // R6
    else $error("done interrupt missing");
  rx_irq_a: assert property (enable_q[serial_pkg::EN_RX] && !enable_q[serial_pkg::EN_STANDBY] // R7
    && enable_q[serial_pkg::EN_RX_FULL_IRQ] && (rx_full_q || overrun_q) |=> irq_out)
    else $error("receive interrupt missing");
  irq_level_a: assert property (!irq_d |=> !irq_out) // R23
    else $error("interrupt without enabled flag");
  tx_clear_a: assert property (wr_data && tx_arm_q && !bit_tick |=> !tx_empty_q && !tx_done_q) // R15
    else $error("buffer empty not cleared");
  rx_load_a: assert property (rx_take |=> rx_full_q && rx_data_q == $past(link.char_data[7:0])) // R18
    else $error("receive buffer not loaded");
  overrun_keep_a: assert property (link.char_valid && rx_full_q && enable_q[serial_pkg::EN_RX] // R20
    && !enable_q[serial_pkg::EN_STANDBY] && !rd_data |=> overrun_q && $stable(rx_data_q))
    else $error("overrun mishandled");
  break_line_a: assert property (tx_state_q == serial_pkg::TX_BREAK && bit_tick // R12
    && tx_count_q > 4'h1 |=> !transmit_pin_out)
    else $error("break not driven low");
  preamble_a: assert property (bit_tick && enable_q[serial_pkg::EN_TX] && !te_prev_q // R9
    && tx_count_q <= 4'h1 |=> tx_state_q == serial_pkg::TX_PREAMBLE && tx_count_q == frame_len)
    else $error("preamble not started");
  load_empty_a: assert property (tx_load |=> tx_empty_q && tx_state_q == serial_pkg::TX_DATA) // R14
    else $error("load did not set empty");

  char_c: cover property (rx_take);
  overrun_c: cover property (overrun_q && rx_full_q);
  break_c: cover property (tx_state_q == serial_pkg::TX_BREAK ##1 tx_state_q == serial_pkg::TX_PREAMBLE);
  done_c: cover property ($rose(tx_done_q));
endmodule
`default_nettype wire

// file: rtl/serial_pkg.sv
// package: register map, field positions and timing counts of the serial control block
package serial_pkg;
  // ---------------------------------------------
  // register byte offsets
  // ---------------------------------------------
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_FORMAT = 4'h4;
  localparam logic [3:0] OFF_ENABLE = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  // ---------------------------------------------
  // frame_format_control bits
  // ---------------------------------------------
  localparam int FMT_RX_NINTH = 7;
  localparam int FMT_TX_NINTH = 6;
  localparam int FMT_NINE_BIT = 4;
  localparam int FMT_ADDR_MARK = 3;
  // ---------------------------------------------
  // serial_enable_control bits
  // ---------------------------------------------
  localparam int EN_TX_EMPTY_IRQ = 7;
  localparam int EN_TX_DONE_IRQ = 6;
  localparam int EN_RX_FULL_IRQ = 5;
  localparam int EN_LINE_QUIET_IRQ = 4;
  localparam int EN_TX = 3;
  localparam int EN_RX = 2;
  localparam int EN_STANDBY = 1;
  localparam int EN_BREAK = 0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  // ---------------------------------------------
  // serial_status_flags bits
  // ---------------------------------------------
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_FULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVERRUN = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 1;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int SAMPLE_DIV = 16;
  localparam int OVERSAMPLE = 16;
  localparam int FRAME_BITS_8 = 10;
  localparam int FRAME_BITS_9 = 11;
  localparam logic [3:0] MID_SAMPLE = 4'h8;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_DATA = 2'b10,
    TX_BREAK = 2'b11
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_WAIT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;
endpackage

// file: rtl/rx_link_if.sv
// interface: carries the sample tick and received characters between control and receiver
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
  logic sample_tick;
  logic nine_bits;
  logic enable;
  logic char_valid;
  logic [8:0] char_data;
  logic char_noise;
  logic char_frame_err;
  logic line_idle;
  modport ctrl (output sample_tick, nine_bits, enable,
                input char_valid, char_data, char_noise, char_frame_err, line_idle);
  modport rx (input sample_tick, nine_bits, enable,
              output char_valid, char_data, char_noise, char_frame_err, line_idle);
endinterface
`default_nettype wire

// file: rtl/serial_rx_sampler.sv
// module: oversampling receiver that recovers characters, noise, framing and idle line
`timescale 1ns/1ps
`default_nettype none
module serial_rx_sampler (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // line
  input wire logic receive_pin_in,
  // control side
  rx_link_if.rx link
);
  logic sync1_q, sync2_q;
  serial_pkg::rx_state_t state_q;
  logic [3:0] sub_q;
  logic [3:0] bitn_q;
  logic [8:0] shift_q;
  logic [2:0] smp_q;
  logic noise_q;
  logic [7:0] ones_q;
  logic idle_done_q;
  logic maj;
  logic [3:0] last_bit;
  logic [7:0] idle_len;
  localparam logic [3:0] MIDM1 = serial_pkg::MID_SAMPLE - 4'h1;
  localparam logic [3:0] MIDP1 = serial_pkg::MID_SAMPLE + 4'h1;
  localparam logic [3:0] MIDP2 = serial_pkg::MID_SAMPLE + 4'h2;

  assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  assign last_bit = link.nine_bits ? 4'h9 : 4'h8;
  assign idle_len = 8'(serial_pkg::OVERSAMPLE * (link.nine_bits ? serial_pkg::FRAME_BITS_9
                                                                 : serial_pkg::FRAME_BITS_8) - 1);

  // ---------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= receive_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------
  // character recovery
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= serial_pkg::RX_WAIT;
      sub_q <= 4'h0;
      bitn_q <= 4'h0;
      shift_q <= 9'h000;
      smp_q <= 3'h7;
      noise_q <= 1'b0;
      link.char_valid <= 1'b0;
      link.char_data <= 9'h000;
      link.char_noise <= 1'b0;
      link.char_frame_err <= 1'b0;
    end else begin
      link.char_valid <= 1'b0;
      if (!link.enable) begin
        state_q <= serial_pkg::RX_WAIT;
      end else if (link.sample_tick) begin
        case (state_q)
          serial_pkg::RX_WAIT: begin
            sub_q <= 4'h0;
            noise_q <= 1'b0;
            bitn_q <= 4'h0;
            if (!sync2_q) begin
              state_q <= serial_pkg::RX_START;
            end
          end
          default: begin
            sub_q <= sub_q + 4'h1;
            if (sub_q >= MIDM1 && sub_q <= MIDP1) begin
              smp_q <= {sync2_q, smp_q[2:1]};
            end
            if (sub_q == MIDP2) begin
              noise_q <= noise_q | (smp_q != 3'h0 && smp_q != 3'h7);
              if (state_q == serial_pkg::RX_START) begin
                state_q <= maj ? serial_pkg::RX_WAIT : serial_pkg::RX_BITS;
              end else if (bitn_q == last_bit) begin
                link.char_valid <= 1'b1;
                link.char_data <= link.nine_bits ? shift_q : {1'b0, shift_q[8:1]};
                link.char_noise <= noise_q | (smp_q != 3'h0 && smp_q != 3'h7);
                link.char_frame_err <= ~maj;
                state_q <= serial_pkg::RX_WAIT;
              end else begin
                shift_q <= {maj, shift_q[8:1]};
                bitn_q <= bitn_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------
  // idle line: a full frame time of ones while waiting
  // ---------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ones_q <= 8'h00;
      idle_done_q <= 1'b0;
      link.line_idle <= 1'b0;
    end else begin
      link.line_idle <= 1'b0;
      if (!link.enable || !sync2_q || state_q != serial_pkg::RX_WAIT) begin
        ones_q <= 8'h00;
        idle_done_q <= 1'b0;
      end else if (link.sample_tick && !idle_done_q) begin
        if (ones_q == idle_len) begin
          link.line_idle <= 1'b1;
          idle_done_q <= 1'b1;
        end else begin
          ones_q <= ones_q + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/serial_far_end.sv
// model: far-end serial device that sends characters and captures transmitted ones
`timescale 1ns/1ps
`default_nettype none
module serial_far_end #(
  parameter int BIT = 16
) (
  // clock and line
  input wire logic clk_in,
  input wire logic tx_line_in,
  output logic rx_line_out
);
  initial rx_line_out = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    @(posedge clk_in);
    rx_line_out <= 1'b0;
    repeat (BIT) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      rx_line_out <= d[i];
      repeat (BIT) @(posedge clk_in);
    end
    rx_line_out <= stop;
    repeat (BIT) @(posedge clk_in);
    rx_line_out <= 1'b1;
  endtask
  task automatic get(input int n, output logic [8:0] d, output int hi);
    hi = 0;
    d = 9'h000;
    while (tx_line_in !== 1'b0 && hi < 20000) begin
      @(posedge clk_in);
      hi++;
    end
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk_in);
      d[i] = tx_line_in;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/async_serial_ctrl_status_bench.sv
// testbench: register and line scenarios for the serial control block
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_status_bench;
  localparam int BT = 16;
  logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack, txp, txd, irq, rxp;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] q;
  logic [8:0] d;
  int n_errors = 0, n_compared = 0, hi;
  always #5 clk = ~clk;
  serial_ctrl #(.SAMPLE_DIV(1)) DUT (.sys_clk_in(clk), .resetn_in(resetn), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .receive_pin_in(rxp), .transmit_pin_out(txp), .transmit_drive_out(txd), .irq_out(irq));
  serial_far_end #(.BIT(BT)) far (.clk_in(clk), .tx_line_in(txp), .rx_line_out(rxp));
  task automatic end_sim();
    $display("counts: %0d compared, %0d bad", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h000000, v};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic grab(input int n, input logic [8:0] e);
    far.get(n, d, hi);
    if (hi >= 20000) begin
      n_errors++;
      end_sim();
    end
    chk(d, e);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(4'hc, 8'hfe, 8'hc0);
    rd(4'h8, 8'hff, 8'h00);
    wb(1'b1, 4'h4, 8'h58);
    rd(4'h4, 8'h58, 8'h58);
    wb(1'b1, 4'h4, 8'h00);
    rd(4'h1, 8'hff, 8'h00);
    wb(1'b1, 4'h8, 8'h80);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, 4'h8, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("test registers done");
    wb(1'b0, 4'hc, 8'h00);
    wb(1'b1, 4'h0, 8'ha5);
    rd(4'hc, 8'hc0, 8'h00);
    wb(1'b1, 4'h8, 8'h48);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    grab(8, 9'h0a5);
    chk(hi >= 150, 1'b1);
    repeat (3 * BT) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, 4'h4, 8'h50);
    rd(4'hc, 8'hc0, 8'hc0);
    wb(1'b1, 4'h0, 8'h3c);
    grab(9, 9'h13c);
    repeat (3 * BT) @(posedge clk);
    $display("test transmit done");
    wb(1'b1, 4'h8, 8'h34);
    far.send(9'h155, 9, 1'b1);
    repeat (4) @(posedge clk);
    chk(irq, 1'b1);
    rd(4'h4, 8'h80, 8'h80);
    rd(4'hc, 8'h20, 8'h20);
    rd(4'h0, 8'hff, 8'h55);
    repeat (12 * BT) @(posedge clk);
    wb(1'b1, 4'h4, 8'h00);
    rd(4'hc, 8'h30, 8'h10);
    chk(irq, 1'b1);
    wb(1'b0, 4'h0, 8'h00);
    far.send(9'h011, 8, 1'b1);
    far.send(9'h022, 8, 1'b0);
    repeat (4) @(posedge clk);
    rd(4'hc, 8'h2e, 8'h28);
    rd(4'h0, 8'hff, 8'h11);
    far.send(9'h033, 8, 1'b0);
    repeat (4) @(posedge clk);
    wb(1'b1, 4'h8, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rd(4'hc, 8'h22, 8'h22);
    wb(1'b1, 4'h8, 8'h06);
    repeat (12 * BT) @(posedge clk);
    rd(4'h8, 8'hff, 8'h04);
    rd(4'hc, 8'h10, 8'h00);
    $display("test receive done");
    wb(1'b1, 4'h8, 8'h09);
    repeat (25 * BT) @(posedge clk);
    chk({txd, txp}, 2'b10);
    wb(1'b1, 4'h8, 8'h08);
    repeat (25 * BT) @(posedge clk);
    chk(txp, 1'b1);
    $display("test break done");
    wb(1'b1, 4'h4, 8'h58);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(4'h4, 8'hd8, 8'hd8);
    rd(4'h8, 8'hff, 8'h00);
    rd(4'hc, 8'hfe, 8'hc0);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
